//--- verif/tcpen_core_sva.sv
// assertion checker for the control word and pen interrupt core
`timescale 1ns/10ps
`default_nettype none
module tcpen_core_sva
  import tcpen_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       screen_touched,
  input wire logic       pen_touch_irq_n_oe,
  input wire logic [2:0] channel_select,
  input wire logic       low_resolution,
  input wire logic       reference_type_select,
  input wire logic       power_option_bit1,
  input wire logic       power_option_bit0,
  input wire logic       pen_detect_enabled,
  input wire logic       word_valid
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  // a word with the always-on setting has just landed
  sequence s_on_loaded;
    word_valid ##1 (power_option_bit1 && power_option_bit0);
  endsequence
  property p_reset_vals;
    !rst_n |=> power_option_bit1 && !power_option_bit0 && pen_detect_enabled
      && !pen_touch_irq_n_oe;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad power-up state");
  property p_touch_irq;
    disable iff (!rst_n) (screen_touched && pen_detect_enabled) [*5] |=> pen_touch_irq_n_oe;
  endproperty
  a_touch_irq: assert property (p_touch_irq) else $error("touch not reported");
  property p_idle_high;
    disable iff (!rst_n) (!screen_touched && pen_detect_enabled) [*6] |=> !pen_touch_irq_n_oe;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("irq low without touch");
  // the interrupt only starts from a touch seen while detection is on
  property p_irq_cause;
    disable iff (!rst_n) $rose(pen_touch_irq_n_oe) |-> $past(screen_touched, 2)
      && ($past(pen_detect_enabled) || $past(pen_detect_enabled, 2));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_lead_off;
    disable iff (!rst_n) word_valid |-> !pen_detect_enabled;
  endproperty
  a_lead_off: assert property (p_lead_off) else $error("detect on after lead");
  property p_on_stays_off;
    disable iff (!rst_n) s_on_loaded |-> !pen_detect_enabled [*8];
  endproperty
  a_on_stays_off: assert property (p_on_stays_off) else $error("detect on at 11");
  property p_reenable;
    disable iff (!rst_n) $rose(pen_detect_enabled) |-> !(power_option_bit1 && power_option_bit0);
  endproperty
  a_reenable: assert property (p_reenable) else $error("bad re-enable");
  // decoded fields move only when a whole word lands
  property p_fields;
    disable iff (!rst_n) $changed({channel_select, low_resolution, reference_type_select,
      power_option_bit1, power_option_bit0}) |-> word_valid || $past(word_valid);
  endproperty
  a_fields: assert property (p_fields) else $error("fields moved");
endmodule
bind tcpen_core tcpen_core_sva i_tcpen_core_sva (.clk_sys, .rst_n, .screen_touched,
  .pen_touch_irq_n_oe, .channel_select, .low_resolution, .reference_type_select,
  .power_option_bit1, .power_option_bit0, .pen_detect_enabled, .word_valid);
`default_nettype wire

//--- verif/tcpen_host_model.sv
// serial host model: frames control words, link clock stands still between frames
`timescale 1ns/10ps
`default_nettype none
module tcpen_host_model
(
  output var logic serial_shift_clock,
  output var logic serial_data_in,
  output var logic chip_select_n
);
  initial
  begin
    serial_shift_clock = 1'b0;
    serial_data_in     = 1'b1;
    chip_select_n      = 1'b1;
  end
  // leading zeros, word msb first, then conversion clocks with zeros on the line
  task automatic send(input logic [7:0] w, input int pre, input int post, input bit keep);
    for (int i = pre + 7; i >= 0; i--)
    begin
      chip_select_n  = 1'b0;
      serial_data_in = (i > 7) ? 1'b0 : w[i];
      #7.5 serial_shift_clock = 1'b1;
      #7.5 serial_shift_clock = 1'b0;
    end
    serial_data_in = 1'b0;
    repeat (post)
    begin
      #7.5 serial_shift_clock = 1'b1;
      #7.5 serial_shift_clock = 1'b0;
    end
    if (!keep)
    begin
      chip_select_n  = 1'b1;
      serial_data_in = 1'b1; // deselected line does not hold the last bit
    end
  endtask
  // link clocks with the block deselected, used around a reset
  task automatic idle(input int n);
    chip_select_n  = 1'b1;
    serial_data_in = 1'b1;
    repeat (n)
    begin
      #7.5 serial_shift_clock = 1'b1;
      #7.5 serial_shift_clock = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- verif/touch_control_word_pen_irq_tb.sv
// self-checking bench for the control word decoder and pen interrupt core
`timescale 1ns/10ps
`default_nettype none
module touch_control_word_pen_irq_tb;
  import tcpen_pkg::*;
  typedef struct packed {logic [7:0] w; logic [7:0] pre; logic [2:0] ch; logic lr;
    logic rs; logic [1:0] pw; logic det;} tcpen_row_t;
  logic clk_sys, rst_n, serial_shift_clock, serial_data_in, chip_select_n, screen_touched;
  logic pen_touch_irq_n_out, pen_touch_irq_n_oe, low_resolution, reference_type_select;
  logic power_option_bit1, power_option_bit0, reference_enable, converter_always_on;
  logic pen_detect_enabled, word_valid;
  logic [2:0] channel_select;
  int errTotal = 0;
  int nChecks = 0;
  // differential only on X, Y and pressure channels; zeros ahead of some leads
  // the differential rows are the X, Z1 and Z2 words a host takes for pressure
  tcpen_row_t rows [5] = '{'{8'h93, 8'h00, 3'h1, 1'h0, 1'h0, 2'h3, 1'h0},
    '{8'hD4, 8'h03, 3'h5, 1'h0, 1'h1, 2'h0, 1'h1}, '{8'hB9, 8'h01, 3'h3, 1'h1, 1'h0, 2'h1, 1'h1},
    '{8'hFE, 8'h00, 3'h7, 1'h1, 1'h1, 2'h2, 1'h1}, '{8'hC0, 8'h02, 3'h4, 1'h0, 1'h0, 2'h0, 1'h1}};
  tcpen_host_model i_tcpen_host_model (.serial_shift_clock, .serial_data_in, .chip_select_n);
  tcpen_core i_tcpen_core (.clk_sys, .rst_n, .serial_shift_clock, .serial_data_in,
    .chip_select_n, .screen_touched, .pen_touch_irq_n_out, .pen_touch_irq_n_oe,
    .channel_select, .low_resolution, .reference_type_select, .power_option_bit1,
    .power_option_bit0, .reference_enable, .converter_always_on, .pen_detect_enabled,
    .word_valid);
  // ********
  // tasks
  // ********
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic closeOut;
    if (errTotal == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // reset with link clocks running inside and after it, as the core needs
  task automatic doReset;
    rst_n = 1'b0;
    fork
      tick(8);
      begin
        tick(1);
        i_tcpen_host_model.idle(4);
      end
    join
    rst_n = 1'b1;
    i_tcpen_host_model.idle(2);
    tick(2);
    chk("reset", 8'h05, {pen_touch_irq_n_oe, power_option_bit1, power_option_bit0,
      pen_detect_enabled});
  endtask
  // bounded wait for the load pulse, a miss ends the run
  task automatic waitValid;
    int i;
    for (i = 0; i < 60 && word_valid !== 1'b1; i++) @(negedge clk_sys);
    if (i == 60)
    begin
      errTotal++;
      closeOut();
    end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ********
  // main sequence
  // ********
  initial
  begin
    screen_touched = 1'b0;
    doReset();
    foreach (rows[k])
    begin
      fork
        i_tcpen_host_model.send(rows[k].w, rows[k].pre, 16, 1'b0);
        waitValid();
      join
      tick(8);
      chk("fields", {rows[k].ch, rows[k].lr, rows[k].rs, rows[k].pw}, {channel_select,
        low_resolution, reference_type_select, power_option_bit1, power_option_bit0});
      chk("power", rows[k].pw, {reference_enable, converter_always_on});
      chk("detect", rows[k].det, pen_detect_enabled);
    end
    // touch, then a word: low holds to the fourth falling edge, then lets go
    screen_touched = 1'b1;
    tick(8);
    chk("irq on", 8'h01, pen_touch_irq_n_oe);
    chk("irq pin", 8'h00, pen_touch_irq_n_out);
    fork
      i_tcpen_host_model.send(8'h90, 0, 16, 1'b0);
      begin
        repeat (3) @(negedge serial_shift_clock);
        tick(1);
        chk("irq held", 8'h01, pen_touch_irq_n_oe);
        @(negedge serial_shift_clock);
        tick(8);
        chk("irq freed", 8'h00, pen_touch_irq_n_oe);
        chk("detect off", 8'h00, pen_detect_enabled);
      end
    join
    tick(8);
    chk("irq again", 8'h01, pen_touch_irq_n_oe);
    // overlapped words: the next lead comes before the conversion end
    screen_touched = 1'b0;
    i_tcpen_host_model.send(8'h90, 0, 7, 1'b1);
    i_tcpen_host_model.send(8'h90, 0, 7, 1'b1);
    tick(4);
    chk("overlap", 8'h00, pen_detect_enabled);
    doReset();
    closeOut();
  end
endmodule
`default_nettype wire

//--- verilog/tcpen_core.sv
// control word decoder and pen touch interrupt, link logic on the shift clock
// Contract
// - with detection enabled a touch drives the pen interrupt low
// - interrupt rests high whenever no touch is being reported
// - recognising a lead bit disables pen detection at once
// - low interrupt holds until fourth falling edge after lead bit, then releases
// - release alone does not re-enable; enabling power bits plus conversion end do
// - pen detection is enabled after power-up
// - overlapped words keep detection disabled since lead bit precedes conversion end
// - first conversion after touch power-up is valid with no extra delay
// - serial input ignored until a lead bit is seen
// - three bits after the lead bit select the channel
// - resolution bit 0 gives 12 bits, 1 gives 8 bits; the conversion end count follows the last channel bit instead
// - reference bit 1 is single-ended, 0 is differential
// - power option bit0 resets to 0, bit1 resets to 1
// - reference enable is independent of converter power state
// - word order lead, channel, resolution, reference, power bit1, bit0
// - power setting 11 disables detection, other settings enable it
`timescale 1ns/10ps
`default_nettype none
module tcpen_core
  import tcpen_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       serial_shift_clock,
  input  wire logic       serial_data_in,
  input  wire logic       chip_select_n,
  input  wire logic       screen_touched,
  output logic            pen_touch_irq_n_out,
  output logic            pen_touch_irq_n_oe,
  output logic [2:0]      channel_select,
  output logic            low_resolution,
  output logic            reference_type_select,
  output logic            power_option_bit1,
  output logic            power_option_bit0,
  output logic            reference_enable,
  output logic            converter_always_on,
  output logic            pen_detect_enabled,
  output logic            word_valid
);
  // ****************************************************************
  // reset carried into the link domain
  // ****************************************************************
  // the link clock may stand still, so reset is asserted into it by a
  // two-flop synchroniser that only releases on link edges; the raw reset
  // is also ANDed in so the link side enters reset with the system side
  // limitation: the host must run a few link clocks during and after reset,
  // otherwise the link registers keep whatever they powered up with
  logic [1:0] linkRstPipe;
  logic       linkRst_n;

  always_ff @(posedge serial_shift_clock)
  begin
    linkRstPipe <= {linkRstPipe[0], rst_n};
  end

  assign linkRst_n = linkRstPipe[1] & rst_n;

  // ****************************************************************
  // link domain: lead bit search and word capture
  // ****************************************************************
  tcpen_state_t state;
  tcpen_state_t next_state;
  logic [2:0]   bitCount;
  logic [6:0]   shiftWord;
  logic [4:0]   fallCount;
  logic         lowRes;
  logic         wordToggle;
  logic         leadToggle;
  logic         endToggle;
  logic         releaseToggle;
  logic [7:0]   capturedWord;

  wire leadSeen   = (state != TCP_WORD) && serial_data_in;
  wire lastBit    = (state == TCP_WORD) && (bitCount == 3'h1);
  wire [4:0] convEnd = lowRes ? CONV_END_8 : CONV_END_12;
  wire [4:0] releaseAt = {1'h0, RELEASE_EDGES} - 5'h01;
  wire [4:0] convEndAt = convEnd - 5'h01;

  // the resolution bit reaches shift register bit 2 only after six rising edges past the lead;
  // it is read on the falling edge after the fifth, when bit 2 holds the last channel bit, ahead of any end count
  localparam logic [4:0]  RES_READ_COUNT = 5'(CW_LEAD - CW_RES + 1);
  localparam int unsigned RES_SHIFT_POS  = CW_RES - 1;

  // sequencer next-state: a lead bit during conversion starts a new word
  always_comb
  begin
    next_state = state;
    case (state)
      TCP_IDLE: next_state = serial_data_in ? TCP_WORD : TCP_IDLE;
      TCP_WORD: next_state = lastBit ? TCP_CONV : TCP_WORD;
      TCP_CONV: next_state = serial_data_in ? TCP_WORD : TCP_CONV;
      default:  next_state = TCP_IDLE;
    endcase
  end

  // rising edges sample input msb first, lead bit included; only a link
  // reset clears the event toggles, since clearing them on a deselect
  // could flip a toggle and fake an event on the system side
  always_ff @(posedge serial_shift_clock)
  begin
    if (!linkRst_n)
    begin
      state        <= TCP_IDLE;
      bitCount     <= 3'h0;
      shiftWord    <= 7'h00;
      capturedWord <= 8'h00;
      leadToggle   <= 1'h0;
      wordToggle   <= 1'h0;
    end
    else if (chip_select_n)
    begin
      // deselect abandons a partial word but keeps the last whole one
      state     <= TCP_IDLE;
      bitCount  <= 3'h0;
      shiftWord <= 7'h00;
    end
    else
    begin
      state <= next_state;
      if (leadSeen)
      begin
        bitCount   <= BITS_AFTER_LEAD;
        leadToggle <= ~leadToggle;
      end
      else if (state == TCP_WORD)
      begin
        bitCount  <= bitCount - 3'h1;
        shiftWord <= {shiftWord[5:0], serial_data_in};
      end
      if (lastBit)
      begin
        capturedWord <= {1'h1, shiftWord[5:0], serial_data_in};
        wordToggle   <= ~wordToggle;
      end
    end
  end

  // falling edges count from the lead bit for release and conversion end
  always_ff @(negedge serial_shift_clock)
  begin
    if (!linkRst_n)
    begin
      fallCount     <= 5'h00;
      lowRes        <= 1'h0;
      endToggle     <= 1'h0;
      releaseToggle <= 1'h0;
    end
    else if (state == TCP_WORD && bitCount == BITS_AFTER_LEAD)
    begin
      fallCount <= 5'h01;
    end
    else if (fallCount != 5'h00)
    begin
      fallCount <= fallCount + 5'h01;
      if (fallCount == releaseAt)
        releaseToggle <= ~releaseToggle;
      if (fallCount == RES_READ_COUNT)
        lowRes <= shiftWord[RES_SHIFT_POS];                            // bit 2 still holds the last channel bit here
      if (fallCount == convEndAt)
      begin
        endToggle <= ~endToggle;
        fallCount <= 5'h00;
      end
    end
  end

  // ****************************************************************
  // crossings into the system domain
  // ****************************************************************
  logic [3:0] evSync;
  logic [3:0] evLast;
  logic       touchSync;

  tcpen_sync2 #(.WIDTH(4)) evCross
  (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .async ({releaseToggle, endToggle, wordToggle, leadToggle}),
    .sync  (evSync)
  );

  tcpen_sync2 #(.WIDTH(1)) touchCross
  (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .async (screen_touched),
    .sync  (touchSync)
  );

  // a toggle flip seen on the system side marks one event; the only data
  // that crosses is capturedWord, which has stood still for two system clock edges
  // by the time its toggle is synchronised, so it needs no synchroniser
  // of its own
  wire leadEvent    = evSync[0] ^ evLast[0];
  wire wordEvent    = evSync[1] ^ evLast[1];
  wire endEvent     = evSync[2] ^ evLast[2];
  wire releaseEvent = evSync[3] ^ evLast[3];

  // ****************************************************************
  // system domain: control register and pen interrupt
  // ****************************************************************
  logic [7:0] ctrlWord;
  logic       detectEn;
  logic       irqLow;

  wire [1:0] pwrBits   = ctrlWord[CW_PWR1:CW_PWR0];
  wire       pwrEnable = (pwrBits != PWR_ALWAYS_ON);
  // a lead in the same cycle as a conversion end wins: in overlapped use the
  // next word has already begun, so detection must stay off
  wire       reenable      = endEvent && pwrEnable;
  wire       next_detectEn = leadEvent ? 1'h0 :
                             reenable ? 1'h1 :
                             detectEn;
  // a touch is taken only while detection is on; with detection off the pin
  // keeps its level until the release event
  wire       touchTaken  = detectEn && touchSync;
  wire       holdLow     = !detectEn && irqLow && !releaseEvent;
  wire       next_irqLow = touchTaken || holdLow;

  // event edges, control word load and detection state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      evLast   <= 4'h0;
      ctrlWord <= {1'h0, 3'h0, 1'h0, 1'h0, PWR1_RESET, PWR0_RESET};
      detectEn <= 1'h1;
      irqLow   <= 1'h0;
    end
    else
    begin
      evLast   <= evSync;
      detectEn <= next_detectEn;
      irqLow   <= next_irqLow;
      if (wordEvent)
        ctrlWord <= capturedWord;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  // field selects out of the loaded word; the converter powers at once on
  // a conversion start, so the first result after a touch needs no wait
  // for the converter itself, only for an external reference to settle
  wire [2:0] chanField = ctrlWord[CW_CH_HI:CW_CH_LO];
  wire       resField  = ctrlWord[CW_RES];
  wire       refField  = ctrlWord[CW_REF];
  wire       pwr1Field = ctrlWord[CW_PWR1];
  wire       pwr0Field = ctrlWord[CW_PWR0];

  // pen pin: open drain, so the data side is a constant low and only the
  // enable moves; the pull-up gives the idle high level
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pen_touch_irq_n_out <= 1'h0;
      pen_touch_irq_n_oe  <= 1'h0;
      pen_detect_enabled  <= 1'h1;
      word_valid          <= 1'h0;
    end
    else
    begin
      pen_touch_irq_n_out <= 1'h0;                                     // open drain: drives low only
      pen_touch_irq_n_oe  <= irqLow;
      pen_detect_enabled  <= detectEn;
      word_valid          <= wordEvent;
    end
  end

  // decoded control fields; reference and converter power follow their
  // own bits, so the reference can be on while the converter sleeps
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      channel_select        <= 3'h0;
      low_resolution        <= 1'h0;
      reference_type_select <= 1'h0;
      power_option_bit1     <= PWR1_RESET;
      power_option_bit0     <= PWR0_RESET;
      reference_enable      <= PWR1_RESET;
      converter_always_on   <= PWR0_RESET;
    end
    else
    begin
      channel_select        <= chanField;
      low_resolution        <= resField;
      reference_type_select <= refField;
      power_option_bit1     <= pwr1Field;
      power_option_bit0     <= pwr0Field;
      reference_enable      <= pwr1Field;
      converter_always_on   <= pwr0Field;
    end
  end
endmodule
`default_nettype wire

//--- verilog/tcpen_pkg.sv
// shared constants for the touch control word and pen interrupt block
package tcpen_pkg;
  // control word layout, lead bit at the top
  localparam int unsigned CW_BITS      = 8;
  localparam int unsigned CW_LEAD      = 7;
  localparam int unsigned CW_CH_HI     = 6;
  localparam int unsigned CW_CH_LO     = 4;
  localparam int unsigned CW_RES       = 3;
  localparam int unsigned CW_REF       = 2;
  localparam int unsigned CW_PWR1      = 1;
  localparam int unsigned CW_PWR0      = 0;
  // power option reset values and the always-on setting
  localparam logic        PWR1_RESET   = 1'h1;
  localparam logic        PWR0_RESET   = 1'h0;
  localparam logic [1:0]  PWR_ALWAYS_ON = 2'h3;
  // falling edges after the lead bit until the interrupt is released
  localparam logic [3:0]  RELEASE_EDGES = 4'h4;
  // falling edges after the lead bit until the conversion ends (8 bit and 12 bit)
  localparam logic [4:0]  CONV_END_12  = 5'h14;
  localparam logic [4:0]  CONV_END_8   = 5'h10;
  localparam logic [2:0]  BITS_AFTER_LEAD = 3'h7;
  // link-side sequencer states, one-hot
  typedef enum logic [2:0]
  {
    TCP_IDLE = 3'h1,
    TCP_WORD = 3'h2,
    TCP_CONV = 3'h4
  } tcpen_state_t;
endpackage

//--- verilog/tcpen_sync2.sv
// two-flop level synchroniser, parameterised width
`timescale 1ns/10ps
`default_nettype none
module tcpen_sync2
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async,
  output var  logic [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      sync   <= '0;
    end
    else
    begin
      stage1 <= async;
      sync   <= stage1;
    end
  end
endmodule
`default_nettype wire
